// >>> design/ilc_pkg.sv
/*
  Shared constants and types for the input loop controller.
  Assumes a single 100 MHz clock and a synchronous link frame port.
*/
// Summary of operation
// (R1) Peripheral in loop-back returns probe to host
// (R2) First answering peripheral gets address one
// (R3) Found peripheral is told to leave loop-back; the code skips this for the seventh, which stays looped back
// (R4) Next answering peripheral gets next address
// (R5) Probe timeout marks previous peripheral as last
// (R6) Last peripheral re-enters loop-back; loop configured
// (R7) At most seven peripherals are enumerated
// (R8) Address equals position counted from host
// (R9) Peripheral type never affects its address
// (R10) Peripheral accepts data addressed to itself
// (R11) Peripheral forwards data addressed to others
// (R12) Controller keeps discovered count, zero to seven
package ilc_pkg;
	localparam int ADDR_W          = 3;
	localparam int DATA_W          = 8;
	localparam int FIFO_DEPTH      = 16;
	localparam int MAX_DEVS        = 7;
	localparam int CLK_PERIOD_NS   = 10;
	localparam int PROBE_TIMEOUT_NS = 50000;
	localparam int PROBE_TIMEOUT_CYC =
		(PROBE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [ADDR_W-1:0] FIRST_ADDR = 3'h1;
	localparam logic [ADDR_W-1:0] LAST_ADDR  = 3'h7;
	localparam logic [ADDR_W-1:0] COUNT_RST  = 3'h0;

	typedef enum logic [1:0] {
		CMD_PROBE,
		CMD_OPEN,
		CMD_CLOSE,
		CMD_DATA
	} ilc_cmd_e;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PROBE_TX,
		ST_WAIT,
		ST_OPEN_TX,
		ST_CLOSE_TX,
		ST_READY
	} ilc_state_e;
endpackage

// >>> design/ilc_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock; depth must be a power of two, at least two.
*/
`timescale 1ns/1ns
module ilc_fifo
	import ilc_pkg::*;
#(
	parameter int WIDTH = ADDR_W + DATA_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic             clk_in,
	input  wire logic             arst_n_in,
	input  wire logic             wr_valid_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	output logic                  wr_ready_out,
	output logic                  rd_valid_out,
	output logic [WIDTH-1:0]      rd_data_out,
	input  wire logic             rd_ready_in
);
	localparam int PW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("ilc_fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW:0]      wr_q;
	logic [PW:0]      wr_d;
	logic [PW:0]      rd_q;
	logic [PW:0]      rd_d;
	logic             push;
	logic             pop;

	always_comb begin
		wr_ready_out = !((wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]));
		rd_valid_out = (wr_q != rd_q);
		rd_data_out  = mem_q[rd_q[PW-1:0]];
		push         = wr_valid_in && wr_ready_out;
		pop          = rd_valid_out && rd_ready_in;
		wr_d         = push ? wr_q + 1'b1 : wr_q;
		rd_d         = pop ? rd_q + 1'b1 : rd_q;
	end

	// Storage has no reset; only the pointers define what is valid
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_q[PW-1:0]] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end
endmodule

// >>> design/ilc_timer.sv
/*
  Probe answer timer: counts while not cleared, flags expiry.
  Assumes clear is held whenever no probe is outstanding.
*/
`timescale 1ns/1ns
module ilc_timer
	import ilc_pkg::*;
#(
	parameter int CYCLES = PROBE_TIMEOUT_CYC
) (
	input  wire logic clk_in,
	input  wire logic arst_n_in,
	input  wire logic clear_in,
	output logic      expired_out
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LIMIT = CW'(CYCLES - 1);

	if (CYCLES < 1) begin : g_bad_cycles
		$error("ilc_timer needs at least one cycle");
	end

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	always_comb begin
		expired_out = (cnt_q == LIMIT);
		if (clear_in) begin
			cnt_d = '0;
		end else if (expired_out) begin
			cnt_d = cnt_q;
		end else begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

// >>> design/ilc_ctrl.sv
/*
  Host-end controller of the input loop: enumerates the chained
  peripherals by loop-back probing, then sends queued user data.
  Assumes the link frame port is synchronous to clk_in and that an
  answer to a probe arrives as a one-cycle rx_valid_in pulse.
*/
`timescale 1ns/1ns
module ilc_ctrl
	import ilc_pkg::*;
#(
	parameter int PROBE_CYCLES = PROBE_TIMEOUT_CYC,
	parameter int DEPTH        = FIFO_DEPTH
) (
	input  wire logic              clk_in,
	input  wire logic              arst_n_in,
	input  wire logic              start_in,
	output logic                   busy_out,
	output logic                   configured_out,
	output logic [ADDR_W-1:0]      dev_count_out,
	input  wire logic              usr_valid_in,
	input  wire logic [ADDR_W-1:0] usr_addr_in,
	input  wire logic [DATA_W-1:0] usr_data_in,
	output logic                   usr_ready_out,
	output logic                   tx_valid_out,
	output ilc_cmd_e               tx_cmd_out,
	output logic [ADDR_W-1:0]      tx_addr_out,
	output logic [DATA_W-1:0]      tx_data_out,
	input  wire logic              tx_ready_in,
	input  wire logic              rx_valid_in,
	input  wire ilc_cmd_e          rx_cmd_in
);
	if (PROBE_CYCLES < 1) begin : g_bad_probe
		$error("ilc_ctrl probe timeout must be at least one cycle");
	end

	ilc_state_e        state_q;
	ilc_state_e        state_d;
	logic [ADDR_W-1:0] count_q;
	logic [ADDR_W-1:0] count_d;
	logic              tx_valid_q;
	logic              tx_valid_d;
	ilc_cmd_e          tx_cmd_q;
	ilc_cmd_e          tx_cmd_d;
	logic [ADDR_W-1:0] tx_addr_q;
	logic [ADDR_W-1:0] tx_addr_d;
	logic [DATA_W-1:0] tx_data_q;
	logic [DATA_W-1:0] tx_data_d;
	logic              q_valid;
	logic              q_pop;
	logic [ADDR_W+DATA_W-1:0] q_word;
	logic              expired;
	logic              answer;

	// User data waits here during enumeration, which back-pressures the source
	ilc_fifo #(
		.WIDTH (ADDR_W + DATA_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_in       (clk_in),
		.arst_n_in    (arst_n_in),
		.wr_valid_in  (usr_valid_in),
		.wr_data_in   ({usr_addr_in, usr_data_in}),
		.wr_ready_out (usr_ready_out),
		.rd_valid_out (q_valid),
		.rd_data_out  (q_word),
		.rd_ready_in  (q_pop)
	);

	ilc_timer #(
		.CYCLES (PROBE_CYCLES)
	) u_timer (
		.clk_in      (clk_in),
		.arst_n_in   (arst_n_in),
		.clear_in    (state_q != ST_WAIT),
		.expired_out (expired)
	);

	// Loop position one further along from the host
	function automatic logic [ADDR_W-1:0] next_pos(input logic [ADDR_W-1:0] pos);
		return pos + 1'b1;
	endfunction

	function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W+DATA_W-1:0] word);
		return word[DATA_W +: ADDR_W];
	endfunction

	// The echoed probe carries no type information, only presence
	assign answer = rx_valid_in && (rx_cmd_in == CMD_PROBE); // R1 R9

	always_comb begin
		state_d    = state_q;
		count_d    = count_q;
		tx_valid_d = tx_valid_q;
		tx_cmd_d   = tx_cmd_q;
		tx_addr_d  = tx_addr_q;
		tx_data_d  = tx_data_q;
		q_pop      = 1'b0;
		if (tx_valid_q && tx_ready_in) begin
			tx_valid_d = 1'b0;
		end
		unique case (state_q)
			ST_IDLE, ST_READY: begin
				// A restart waits for any pending frame so none is cut in half
				if (start_in && !tx_valid_q) begin
					count_d    = COUNT_RST;
					tx_valid_d = 1'b1;
					tx_cmd_d   = CMD_PROBE;
					tx_addr_d  = FIRST_ADDR; // R2
					state_d    = ST_PROBE_TX;
				end else if (state_q == ST_READY && q_valid
						&& (!tx_valid_q || tx_ready_in)) begin
					q_pop = 1'b1;
					// Frames to an empty position are dropped: nobody would take them
					if (word_addr(q_word) != COUNT_RST && word_addr(q_word) <= count_q) begin
						tx_valid_d = 1'b1;
						tx_cmd_d   = CMD_DATA;
						tx_addr_d  = word_addr(q_word); // R10 R11
						tx_data_d  = q_word[DATA_W-1:0];
					end
				end
			end
			ST_PROBE_TX: begin
				if (tx_ready_in) begin
					state_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (answer) begin
					count_d = next_pos(count_q); // R8 R12
					if (next_pos(count_q) == LAST_ADDR) begin
						// Seventh device is still looped back, so the loop is closed
						state_d = ST_READY; // R7
					end else begin
						tx_valid_d = 1'b1;
						tx_cmd_d   = CMD_OPEN; // R3
						tx_addr_d  = next_pos(count_q);
						state_d    = ST_OPEN_TX;
					end
				end else if (expired) begin
					if (count_q == COUNT_RST) begin
						state_d = ST_READY; // R5
					end else begin
						tx_valid_d = 1'b1;
						tx_cmd_d   = CMD_CLOSE; // R5 R6
						tx_addr_d  = count_q;
						state_d    = ST_CLOSE_TX;
					end
				end
			end
			ST_OPEN_TX: begin
				if (tx_ready_in) begin
					tx_valid_d = 1'b1;
					tx_cmd_d   = CMD_PROBE;
					tx_addr_d  = next_pos(count_q); // R4 R8
					state_d    = ST_PROBE_TX;
				end
			end
			ST_CLOSE_TX: begin
				if (tx_ready_in) begin
					state_d = ST_READY; // R6
				end
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q    <= ST_IDLE;
			count_q    <= COUNT_RST;
			tx_valid_q <= 1'b0;
			tx_cmd_q   <= CMD_PROBE;
			tx_addr_q  <= COUNT_RST;
			tx_data_q  <= '0;
		end else begin
			state_q    <= state_d;
			count_q    <= count_d;
			tx_valid_q <= tx_valid_d;
			tx_cmd_q   <= tx_cmd_d;
			tx_addr_q  <= tx_addr_d;
			tx_data_q  <= tx_data_d;
		end
	end

	assign tx_valid_out   = tx_valid_q;
	assign tx_cmd_out     = tx_cmd_q;
	assign tx_addr_out    = tx_addr_q;
	assign tx_data_out    = tx_data_q;
	assign dev_count_out  = count_q; // R12
	assign configured_out = (state_q == ST_READY);
	assign busy_out       = (state_q != ST_IDLE) && (state_q != ST_READY);

	// Each check below watches what the controller itself launches
	property p_first_probe;
		@(posedge clk_in) disable iff (!arst_n_in)
		(state_q == ST_IDLE && start_in)
			|=> tx_valid_out && tx_cmd_out == CMD_PROBE && tx_addr_out == 3'h1
			&& dev_count_out == 3'h0;
	endproperty
	a_first_probe: assert property (p_first_probe) // R2
		else $error("First probe not sent to address one");

	property p_open_found;
		@(posedge clk_in) disable iff (!arst_n_in)
		(state_q == ST_WAIT && answer && count_q < 3'h6)
			|=> tx_valid_out && tx_cmd_out == CMD_OPEN && tx_addr_out == count_q;
	endproperty
	a_open_found: assert property (p_open_found) // R3
		else $error("Found peripheral not told to leave loop-back");

	property p_next_probe;
		@(posedge clk_in) disable iff (!arst_n_in)
		(state_q == ST_OPEN_TX && tx_ready_in)
			|=> tx_cmd_out == CMD_PROBE && tx_addr_out == $past(tx_addr_out) + 3'h1;
	endproperty
	a_next_probe: assert property (p_next_probe) // R4
		else $error("Next probe not sent to the next address");

	property p_timeout;
		@(posedge clk_in) disable iff (!arst_n_in)
		(state_q == ST_WAIT && expired && !answer)
			|=> $stable(dev_count_out) && (state_q == ST_CLOSE_TX || state_q == ST_READY);
	endproperty
	a_timeout: assert property (p_timeout) // R5
		else $error("Probe timeout did not end the search");

	property p_close_last;
		@(posedge clk_in) disable iff (!arst_n_in)
		(state_q == ST_CLOSE_TX)
			|-> tx_valid_out && tx_cmd_out == CMD_CLOSE && tx_addr_out == dev_count_out;
	endproperty
	a_close_last: assert property (p_close_last) // R6
		else $error("Last peripheral not closed before configured");

	property p_close_done;
		@(posedge clk_in) disable iff (!arst_n_in)
		(state_q == ST_CLOSE_TX && tx_ready_in) |=> configured_out && !tx_valid_out;
	endproperty
	a_close_done: assert property (p_close_done) // R6
		else $error("Loop not configured after closing the last peripheral");

	property p_max_seven;
		@(posedge clk_in) disable iff (!arst_n_in)
		(state_q == ST_WAIT && answer && count_q == 3'h6)
			|=> configured_out && dev_count_out == 3'h7 && !tx_valid_out;
	endproperty
	a_max_seven: assert property (p_max_seven) // R7
		else $error("Search went on past seven peripherals");

	property p_probe_position;
		@(posedge clk_in) disable iff (!arst_n_in)
		(tx_valid_out && tx_cmd_out == CMD_PROBE)
			|-> tx_addr_out == dev_count_out + 3'h1;
	endproperty
	a_probe_position: assert property (p_probe_position) // R8
		else $error("Probe address differs from loop position");

	property p_count_step;
		@(posedge clk_in) disable iff (!arst_n_in)
		(state_q == ST_WAIT && answer)
			|=> dev_count_out == $past(dev_count_out) + 3'h1;
	endproperty
	a_count_step: assert property (p_count_step) // R9
		else $error("Answer did not add exactly one peripheral");

	property p_count_held;
		@(posedge clk_in) disable iff (!arst_n_in)
		(configured_out && !start_in) |=> $stable(dev_count_out);
	endproperty
	a_count_held: assert property (p_count_held) // R12
		else $error("Peripheral count changed while configured");

	// An empty loop has nobody to close, so it is configured at once
	property p_zero_found;
		@(posedge clk_in) disable iff (!arst_n_in)
		(state_q == ST_WAIT && expired && !answer && count_q == COUNT_RST)
			|=> configured_out && !tx_valid_out && dev_count_out == COUNT_RST;
	endproperty
	a_zero_found: assert property (p_zero_found) // R5
		else $error("Empty loop not configured after the first timeout");

	property p_wait_bounded;
		@(posedge clk_in) disable iff (!arst_n_in)
		(state_q == ST_WAIT && expired)
			|=> state_q != ST_WAIT;
	endproperty
	a_wait_bounded: assert property (p_wait_bounded) // R5
		else $error("Controller kept waiting after the probe timeout");

	property p_data_addr;
		@(posedge clk_in) disable iff (!arst_n_in)
		(tx_valid_out && tx_cmd_out == CMD_DATA)
			|-> tx_addr_out != COUNT_RST && tx_addr_out <= dev_count_out;
	endproperty
	a_data_addr: assert property (p_data_addr) // R10
		else $error("Data frame sent to a position with no peripheral");

	// A frame that the link has not taken must not change under it
	property p_frame_hold;
		@(posedge clk_in) disable iff (!arst_n_in)
		(tx_valid_out && !tx_ready_in)
			|=> tx_valid_out && $stable(tx_cmd_out) && $stable(tx_addr_out) && $stable(tx_data_out);
	endproperty
	a_frame_hold: assert property (p_frame_hold) // R10
		else $error("Link frame changed before it was taken");
endmodule

// >>> tb/ilc_chain_model.sv
/*
  Behavioural chain of loop peripherals facing the controller's link port.
  Assumes frames are taken on rising edges of the controller's clock.
*/
`timescale 1ns/1ns
module ilc_chain_model
	import ilc_pkg::*;
(
	input  wire logic                     clk_in,
	input  wire logic                     arst_n_in,
	input  wire logic [3:0]               devs_in,
	input  wire logic                     slow_in,
	input  wire logic                     stall_in,
	input  wire logic                     tx_valid_in,
	input  wire ilc_cmd_e                 tx_cmd_in,
	input  wire logic [ADDR_W-1:0]        tx_addr_in,
	input  wire logic [DATA_W-1:0]        tx_data_in,
	output logic                          tx_ready_out,
	output logic                          rx_valid_out,
	output ilc_cmd_e                      rx_cmd_out,
	output logic                          got_out,
	output logic [ADDR_W+DATA_W-1:0]      got_word_out
);
	int open_q;
	int wait_q;
	assign tx_ready_out = !stall_in;
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			open_q <= 0;
			wait_q <= 0;
			rx_valid_out <= 1'b0;
			rx_cmd_out <= CMD_DATA;
			got_out <= 1'b0;
			got_word_out <= '0;
		end else begin
			rx_valid_out <= 1'b0;
			// Idle command toggles so a stale value never looks meaningful
			rx_cmd_out <= ilc_cmd_e'(~rx_cmd_out);
			got_out <= 1'b0;
			if (wait_q == 1) begin
				rx_valid_out <= 1'b1;
				rx_cmd_out <= CMD_PROBE;
			end
			if (wait_q > 0)
				wait_q <= wait_q - 1;
			if (tx_valid_in && tx_ready_out) begin
				case (tx_cmd_in)
				// Only the first looped-back unit sees a probe
				CMD_PROBE: if (int'(tx_addr_in) == open_q + 1 && open_q < int'(devs_in))
					wait_q <= slow_in ? 6 : 2;
				CMD_OPEN: open_q <= int'(tx_addr_in);
				CMD_CLOSE: open_q <= int'(tx_addr_in) - 1;
				default: if (tx_addr_in != 0 && int'(tx_addr_in) <= open_q + 1) begin
					got_out <= 1'b1;
					got_word_out <= {tx_addr_in, tx_data_in};
				end
				endcase
			end
		end
	end
endmodule

// >>> tb/tb_input_loop_link_enumeration.sv
/*
  Self-checking bench for the loop controller with a peripheral chain model.
  Assumes a 100 MHz clock and a shortened probe timeout of 8 cycles.
*/
`timescale 1ns/1ns
module tb_input_loop_link_enumeration
	import ilc_pkg::*;
;
	logic clk_in, arst_n, start, busy, cfg, usr_valid, usr_ready, tx_valid, tx_ready;
	logic rx_valid, slow, stall, got;
	logic [ADDR_W-1:0] cnt, usr_addr, tx_addr;
	logic [DATA_W-1:0] usr_data, tx_data;
	logic [3:0] devs;
	logic [10:0] got_word;
	ilc_cmd_e tx_cmd, rx_cmd;
	logic [4:0] frames[$];
	logic [10:0] words[$];
	logic [10:0] exp_w[$];
	int miscompares, compares;
	int cyc = 0;

	ilc_ctrl #(.PROBE_CYCLES(8), .DEPTH(16)) uut (.clk_in(clk_in), .arst_n_in(arst_n),
		.start_in(start), .busy_out(busy), .configured_out(cfg), .dev_count_out(cnt),
		.usr_valid_in(usr_valid), .usr_addr_in(usr_addr), .usr_data_in(usr_data),
		.usr_ready_out(usr_ready), .tx_valid_out(tx_valid), .tx_cmd_out(tx_cmd),
		.tx_addr_out(tx_addr), .tx_data_out(tx_data), .tx_ready_in(tx_ready),
		.rx_valid_in(rx_valid), .rx_cmd_in(rx_cmd));
	ilc_chain_model chain (.clk_in(clk_in), .arst_n_in(arst_n), .devs_in(devs),
		.slow_in(slow), .stall_in(stall), .tx_valid_in(tx_valid), .tx_cmd_in(tx_cmd),
		.tx_addr_in(tx_addr), .tx_data_in(tx_data), .tx_ready_out(tx_ready),
		.rx_valid_out(rx_valid), .rx_cmd_out(rx_cmd), .got_out(got),
		.got_word_out(got_word));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	task automatic close_out();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Frame and delivery log; the cycle ceiling cuts a hang short
	always @(posedge clk_in) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			frames.push_back({tx_cmd, tx_addr});
		if (got === 1'b1)
			words.push_back(got_word);
		cyc++;
		if (cyc == 30000) begin
			miscompares++;
			close_out();
		end
	end

	task automatic do_reset(input int n, input logic s);
		@(posedge clk_in);
		arst_n <= 1'b0;
		devs <= 4'(n);
		slow <= s;
		repeat (6) @(posedge clk_in);
		arst_n <= 1'b1;
		frames.delete();
		words.delete();
		chk(16'(cnt), 16'h0);
		chk(16'(tx_valid), 16'h0);
	endtask

	task automatic enumerate();
		int t;
		start <= 1'b1;
		@(posedge clk_in);
		start <= 1'b0;
		t = 0;
		while (cfg !== 1'b1 && t < 500) begin
			@(posedge clk_in);
			t++;
		end
		@(negedge clk_in);
		chk(16'(cfg), 16'h1);
	endtask

	// Expected frame order is rebuilt from the chain length alone
	task automatic enum_case(input int n, input logic s);
		logic [4:0] e[$];
		int f;
		do_reset(n, s);
		enumerate();
		f = (n > 7) ? 7 : n;
		for (int k = 1; k <= f; k++) begin
			e.push_back({CMD_PROBE, 3'(k)});
			if (k < 7)
				e.push_back({CMD_OPEN, 3'(k)});
		end
		if (f < 7)
			e.push_back({CMD_PROBE, 3'(f + 1)});
		if (f > 0 && f < 7)
			e.push_back({CMD_CLOSE, 3'(f)});
		chk(16'(frames.size()), 16'(e.size()));
		foreach (e[i])
			if (i < frames.size())
				chk(16'(frames[i]), 16'(e[i]));
		chk(16'(cnt), 16'(f));
		chk(16'(busy), 16'h0);
	endtask

	// Fill the queue against a stalled link, then drain it
	task automatic data_case();
		int i, t;
		do_reset(3, 1'b0);
		enumerate();
		@(posedge clk_in);
		stall <= 1'b1;
		i = 0;
		while (i < 40) begin
			@(posedge clk_in);
			usr_valid <= 1'b1;
			usr_addr <= 3'(i % 5);
			usr_data <= 8'(i + 8'h30);
			@(negedge clk_in);
			if (usr_ready !== 1'b1)
				break;
			if (i % 5 != 0 && i % 5 <= 3)
				exp_w.push_back({3'(i % 5), 8'(i + 8'h30)});
			i++;
		end
		@(posedge clk_in);
		usr_valid <= 1'b0;
		chk(16'(i < 40), 16'h1);
		chk(16'(tx_valid), 16'h1);
		stall <= 1'b0;
		t = 0;
		while (words.size() < exp_w.size() && t < 300) begin
			@(posedge clk_in);
			t++;
		end
		repeat (4) @(posedge clk_in);
		chk(16'(words.size()), 16'(exp_w.size()));
		foreach (exp_w[k])
			if (k < words.size())
				chk(16'(words[k]), 16'(exp_w[k]));
	endtask

	initial begin
		arst_n = 1'b0;
		start = 1'b0;
		usr_valid = 1'b0;
		usr_addr = '0;
		usr_data = '0;
		devs = 4'h0;
		slow = 1'b0;
		stall = 1'b0;
		miscompares = 0;
		compares = 0;
		enum_case(3, 1'b1);
		enum_case(0, 1'b0);
		enum_case(7, 1'b0);
		enum_case(9, 1'b1);
		data_case();
		close_out();
	end
endmodule
